// ==== srpc_ctrl.sv ====
// sdram controller: border handling, auto-refresh, low-power modes, registers
//
// Contract
// - row boundary crossing: precharge, activate new row, reissue access
// - extra cycle between precharge and activate, and activate and access
// - controller issues auto-refresh itself; memory makes refresh rows
// - 12-bit refresh count reloads a cycle timer whose expiry requests refresh
// - no refresh at all until software writes the refresh count; a wake from power-down without an access still requests one
// - refresh due while previous one still pending raises refresh error
// - reading interrupt status clears the refresh error flag
// - sdram accesses wait while refresh runs; registers are never delayed
// - low-power mode entered once memory is idle, unless timeout set
// - self-refresh or power-down entry delayed by programmed timeout
// - timeout 00 none, 01 64 cycles, 10 128 cycles, 11 reserved
// - select 1: self-refresh, memory clock stopped, clock enable low
// - access during self-refresh runs exit sequence before the access
// - self-refresh held at least the active-to-precharge delay
// - select 2: power-down after each access, clock enable low
// - in power-down controller wakes memory to keep refreshing
// - select 3: deep power-down command, contents lost
// - low-power parameters held in register, sent by extended load mode
// - 3-bit command mode chooses command issued on each sdram access
// - new command mode takes effect on next sdram write; here leaving deep power-down also makes it live
// - writing 1 to enable-set refresh error bit enables interrupt
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module srpc_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [8:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq_o,
  output logic sdram_wait_o,
  output srpc_pkg::srpc_mem_t mem_o
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_PRE, ST_PRE_GAP, ST_ACT, ST_ACT_GAP, ST_XFER, ST_REFRESH,
    ST_SREF, ST_SREF_EXIT, ST_PDOWN, ST_DPD, ST_MODE_CMD
  } srpc_st_t;

  typedef struct packed {
    srpc_st_t st;
    logic [2:0] mode_reg;
    logic [2:0] mode_live;
    logic [11:0] count;
    logic count_written;
    logic [11:0] timer;
    logic rfsh_pend;
    logic [31:0] cfg;
    logic [31:0] lp;
    logic err_flag;
    logic err_mask;
    logic [1:0] mtype;
    logic [3:0] wcnt;
    logic [7:0] idle_cnt;
    logic [22:0] pd_cnt;
    logic row_open;
    logic [12:0] open_row;
    logic ack;
    logic [31:0] rdata;
    srpc_pkg::srpc_mem_t mem;
  } srpc_state_t;

  srpc_state_t s_q, s_d;

  logic req;
  logic sdram_req;
  logic reg_req;
  logic [12:0] req_row;
  logic [1:0] lp_sel;
  logic [1:0] lp_tmo;
  logic [3:0] trp;
  logic [3:0] trcd;
  logic [3:0] tras;
  logic [3:0] txsr;
  logic [3:0] trc;
  logic tmo_done;

  // ----------------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------------
  // sdram space: column in adr_i[3:0], row in adr_i[7:4] (compact window)
  assign req = cyc_i && stb_i && !s_q.ack;
  assign sdram_req = req && adr_i[srpc_pkg::SDRAM_SEL_BIT];
  assign reg_req = req && !adr_i[srpc_pkg::SDRAM_SEL_BIT];
  assign req_row = {9'h000, adr_i[7:4]};
  assign lp_sel = s_q.lp[srpc_pkg::LP_SEL_LSB +: 2];
  assign lp_tmo = s_q.lp[srpc_pkg::LP_TMO_LSB +: 2];
  assign trp = s_q.cfg[srpc_pkg::CR_TRP_LSB +: 4];
  assign trcd = s_q.cfg[srpc_pkg::CR_TRCD_LSB +: 4];
  assign tras = s_q.cfg[srpc_pkg::CR_TRAS_LSB +: 4];
  assign txsr = s_q.cfg[srpc_pkg::CR_TXSR_LSB +: 4];
  assign trc = s_q.cfg[srpc_pkg::CR_TRC_LSB +: 4];

  // timeout selection; reserved code behaves as immediate
  always_comb begin
    case (lp_tmo)
      2'b01: tmo_done = (s_q.idle_cnt >= 8'(srpc_pkg::TMO_SHORT_CYC));
      2'b10: tmo_done = (s_q.idle_cnt >= 8'(srpc_pkg::TMO_LONG_CYC));
      default: tmo_done = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.mem.cmd = srpc_pkg::CMD_NOP;
    s_d.mem.cs_n = 1'b0;
    s_d.mem.a10 = 1'b0; // all-banks flag lasts only its own command
    // register slave answers in one cycle, never held by refresh
    if (reg_req) begin
      s_d.ack = 1'b1;
      s_d.rdata = 32'h0000_0000;
      if (we_i && sel_i == 4'hf) begin
        if (adr_i[7:0] == srpc_pkg::OFS_COMMAND_MODE) begin
          s_d.mode_reg = dat_i[2:0];
        end else if (adr_i[7:0] == srpc_pkg::OFS_REFRESH_TIMER) begin
          s_d.count = dat_i[11:0];
          s_d.timer = dat_i[11:0];
          s_d.count_written = 1'b1;
        end else if (adr_i[7:0] == srpc_pkg::OFS_TIMING_CONFIGURATION) begin
          s_d.cfg = dat_i;
        end else if (adr_i[7:0] == srpc_pkg::OFS_LOW_POWER_CONTROL) begin
          s_d.lp = dat_i & 32'h0000_3f73;
        end else if (adr_i[7:0] == srpc_pkg::OFS_IRQ_ENABLE_SET) begin
          if (dat_i[srpc_pkg::IRQ_RES_BIT]) s_d.err_mask = 1'b1;
        end else if (adr_i[7:0] == srpc_pkg::OFS_IRQ_ENABLE_CLEAR) begin
          if (dat_i[srpc_pkg::IRQ_RES_BIT]) s_d.err_mask = 1'b0;
        end else if (adr_i[7:0] == srpc_pkg::OFS_MEMORY_TYPE_SELECT) begin
          s_d.mtype = dat_i[1:0];
        end
      end else if (!we_i) begin
        if (adr_i[7:0] == srpc_pkg::OFS_COMMAND_MODE) begin
          s_d.rdata = {29'h0, s_q.mode_reg};
        end else if (adr_i[7:0] == srpc_pkg::OFS_REFRESH_TIMER) begin
          s_d.rdata = {20'h0, s_q.count};
        end else if (adr_i[7:0] == srpc_pkg::OFS_TIMING_CONFIGURATION) begin
          s_d.rdata = s_q.cfg;
        end else if (adr_i[7:0] == srpc_pkg::OFS_LOW_POWER_CONTROL) begin
          s_d.rdata = s_q.lp;
        end else if (adr_i[7:0] == srpc_pkg::OFS_IRQ_MASK_STATE) begin
          s_d.rdata = {31'h0, s_q.err_mask};
        end else if (adr_i[7:0] == srpc_pkg::OFS_IRQ_STATUS) begin
          s_d.rdata = {31'h0, s_q.err_flag};
          s_d.err_flag = 1'b0;
        end else if (adr_i[7:0] == srpc_pkg::OFS_MEMORY_TYPE_SELECT) begin
          s_d.rdata = {30'h0, s_q.mtype};
        end
      end
    end

    // refresh timer: reload on expiry, error if previous still pending
    if (s_q.count_written && s_q.st != srpc_st_t'(ST_DPD)) begin
      if (s_q.timer == 12'h000) begin
        s_d.timer = s_q.count;
        s_d.rfsh_pend = 1'b1;
        if (s_q.rfsh_pend) s_d.err_flag = 1'b1;
      end else begin
        s_d.timer = s_q.timer - 12'h001;
      end
    end

    // idle and power-down counters
    s_d.idle_cnt = (s_q.st == ST_IDLE && s_q.idle_cnt != 8'hff) ?
      s_q.idle_cnt + 8'h01 : s_q.idle_cnt;
    s_d.pd_cnt = (s_q.st == ST_PDOWN) ? s_q.pd_cnt + 23'h1 : 23'h0;
    if (s_q.wcnt != 4'h0) s_d.wcnt = s_q.wcnt - 4'h1;

    case (s_q.st)
      ST_IDLE: begin
        // wait out trp after a precharge before the refresh
        if (s_q.rfsh_pend && s_q.wcnt == 4'h0) begin
          s_d.mem.cmd = s_q.row_open ? srpc_pkg::CMD_PRECHARGE
                                     : srpc_pkg::CMD_REFRESH;
          if (!s_q.row_open) begin
            s_d.rfsh_pend = (s_q.timer == 12'h000);
            s_d.st = ST_REFRESH;
            s_d.wcnt = trc;
          end else begin
            s_d.row_open = 1'b0;
            s_d.wcnt = trp;
          end
        end else if (sdram_req && s_q.wcnt == 4'h0) begin
          s_d.idle_cnt = 8'h00;
          if (we_i) s_d.mode_live = s_q.mode_reg;
          if ((we_i ? s_q.mode_reg : s_q.mode_live) != 3'(srpc_pkg::MODE_NORMAL))
          begin
            s_d.st = ST_MODE_CMD;
          end else if (s_q.row_open && s_q.open_row != req_row) begin
            s_d.mem.cmd = srpc_pkg::CMD_PRECHARGE;
            s_d.row_open = 1'b0;
            s_d.wcnt = trp;
            s_d.st = ST_PRE_GAP;
          end else if (!s_q.row_open) begin
            s_d.st = ST_ACT;
          end else begin
            s_d.st = ST_XFER;
          end
        end else if (s_q.wcnt == 4'h0 && lp_sel != 2'b00 && tmo_done &&
                     s_q.mode_live == 3'(srpc_pkg::MODE_NORMAL)) begin
          // enter low power once idle and timeout run out
          s_d.row_open = 1'b0;
          if (lp_sel == 2'b01) begin
            s_d.mem.cmd = srpc_pkg::CMD_REFRESH;
            s_d.mem.cke = 1'b0;
            s_d.wcnt = tras;
            s_d.st = ST_SREF;
          end else if (lp_sel == 2'b10) begin
            s_d.mem.cke = 1'b0;
            s_d.st = ST_PDOWN;
          end else begin
            s_d.mem.cmd = srpc_pkg::CMD_BURST_STOP;
            s_d.mem.cke = 1'b0;
            s_d.st = ST_DPD;
          end
        end
      end
      ST_PRE_GAP: begin
        // extra cycle after precharge before activate
        if (s_q.wcnt == 4'h0) s_d.st = ST_ACT;
      end
      ST_ACT: begin
        s_d.mem.cmd = srpc_pkg::CMD_ACTIVE;
        s_d.mem.addr = req_row;
        s_d.mem.ba = adr_i[1:0];
        s_d.row_open = 1'b1;
        s_d.open_row = req_row;
        s_d.wcnt = trcd;
        s_d.st = ST_ACT_GAP;
      end
      ST_ACT_GAP: begin
        // extra cycle after activate before the column access
        if (s_q.wcnt == 4'h0) s_d.st = ST_XFER;
      end
      ST_XFER: begin
        s_d.mem.cmd = we_i ? srpc_pkg::CMD_WRITE : srpc_pkg::CMD_READ;
        s_d.mem.addr = {9'h000, adr_i[3:0]};
        s_d.rdata = 32'h0000_0000;
        s_d.ack = 1'b1;
        s_d.idle_cnt = 8'h00;
        s_d.st = ST_IDLE;
      end
      ST_MODE_CMD: begin
        s_d.ack = 1'b1;
        s_d.st = ST_IDLE;
        s_d.mem.ba = adr_i[1:0]; // bank from address
        s_d.mem.addr = {9'h000, adr_i[7:4]};
        case (srpc_pkg::srpc_mode_t'(s_q.mode_live))
          srpc_pkg::MODE_NOP: s_d.mem.cmd = srpc_pkg::CMD_NOP;
          srpc_pkg::MODE_PRECHARGE_ALL: begin
            s_d.mem.cmd = srpc_pkg::CMD_PRECHARGE;
            s_d.mem.a10 = 1'b1;
            s_d.row_open = 1'b0;
          end
          srpc_pkg::MODE_LOAD_MODE: s_d.mem.cmd = srpc_pkg::CMD_LOAD_MODE;
          srpc_pkg::MODE_AUTO_REFRESH: s_d.mem.cmd = srpc_pkg::CMD_REFRESH;
          srpc_pkg::MODE_EXT_LOAD_MODE: begin
            s_d.mem.cmd = srpc_pkg::CMD_LOAD_MODE;
            s_d.mem.addr = {5'h00, s_q.lp[15:8] & 8'h3f} |
                           {10'h000, s_q.lp[6:4]};
          end
          srpc_pkg::MODE_DEEP_PD: begin
            s_d.mem.cmd = srpc_pkg::CMD_BURST_STOP;
            s_d.mem.cke = 1'b0;
            s_d.st = ST_DPD;
          end
          default: s_d.mem.cmd = srpc_pkg::CMD_NOP;
        endcase
      end
      ST_REFRESH: begin
        // bus held off by sdram_wait_o until refresh cycle time passes
        if (s_q.wcnt == 4'h0) s_d.st = ST_IDLE;
      end
      ST_SREF: begin
        s_d.mem.cke = 1'b0;
        s_d.mem.clk_en = (s_q.wcnt != 4'h0) ? s_q.mem.clk_en : 1'b0;
        // exit only after minimum stay, on access or on select change
        if (s_q.wcnt == 4'h0 && (sdram_req || lp_sel != 2'b01)) begin
          s_d.mem.cke = 1'b1;
          s_d.mem.clk_en = 1'b1;
          s_d.wcnt = txsr;
          s_d.st = ST_SREF_EXIT;
        end
      end
      ST_SREF_EXIT: begin
        if (s_q.wcnt == 4'h0) begin
          s_d.st = ST_IDLE;
          s_d.rfsh_pend = 1'b0;
        end
      end
      ST_PDOWN: begin
        // wake for access, pending refresh or max stay
        if (sdram_req || s_q.rfsh_pend || lp_sel != 2'b10 ||
            s_q.pd_cnt >= 23'(srpc_pkg::PD_MAX_CYC - 1)) begin
          s_d.mem.cke = 1'b1;
          s_d.idle_cnt = 8'h00;
          s_d.rfsh_pend = s_q.rfsh_pend || !sdram_req;
          s_d.st = ST_IDLE;
        end
      end
      ST_DPD: begin
        // left only once software clears both the select and the deep power-down command mode; contents lost
        s_d.mem.cke = 1'b0;
        s_d.mem.clk_en = 1'b0;
        if (lp_sel != 2'b11 && s_q.mode_reg != 3'(srpc_pkg::MODE_DEEP_PD)) begin
          s_d.mem.cke = 1'b1;
          s_d.mem.clk_en = 1'b1;
          s_d.mode_live = s_q.mode_reg;
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.cfg <= srpc_pkg::RST_TIMING_CONFIGURATION;
      s_q.mem.cs_n <= 1'b1;
      s_q.mem.cmd <= srpc_pkg::CMD_NOP;
      s_q.mem.cke <= 1'b1;
      s_q.mem.clk_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign dat_o = s_q.rdata;
  assign ack_o = s_q.ack;
  assign irq_o = s_q.err_flag && s_q.err_mask;
  assign mem_o = s_q.mem;
  assign sdram_wait_o = (s_q.st == ST_REFRESH) || s_q.rfsh_pend;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_no_rfsh_unwritten: assert property (
    !s_q.count_written |-> mem_o.cmd != srpc_pkg::CMD_REFRESH ||
      s_q.mode_live == 3'(srpc_pkg::MODE_AUTO_REFRESH))
    else $error("refresh issued before count written");
  chk_err_on_overrun: assert property (
    s_q.count_written && s_q.timer == 12'h000 && s_q.rfsh_pend &&
    s_q.st != ST_DPD |=> s_q.err_flag)
    else $error("refresh overrun not flagged");
  chk_status_clear: assert property (
    reg_req && !we_i && adr_i[7:0] == srpc_pkg::OFS_IRQ_STATUS &&
    !(s_q.count_written && s_q.timer == 12'h000 && s_q.rfsh_pend)
    |=> !s_q.err_flag)
    else $error("status read did not clear error");
  chk_irq_mask_set: assert property (
    reg_req && we_i && sel_i == 4'hf &&
    adr_i[7:0] == srpc_pkg::OFS_IRQ_ENABLE_SET && dat_i[0] |=> s_q.err_mask)
    else $error("enable set ignored");
  chk_irq_out: assert property (
    irq_o == (s_q.err_flag && s_q.err_mask))
    else $error("irq output mismatch");
  chk_reg_fast: assert property (
    reg_req |=> ack_o)
    else $error("register access delayed");
  chk_pre_gap: assert property (
    s_q.st == ST_IDLE && s_d.st == ST_PRE_GAP |=> mem_o.cmd ==
      srpc_pkg::CMD_PRECHARGE ##1 mem_o.cmd != srpc_pkg::CMD_ACTIVE)
    else $error("no gap after precharge");
  chk_sref_cke: assert property (
    s_q.st == ST_SREF && $past(s_q.st) == ST_SREF && s_d.st == ST_SREF
    |-> !mem_o.cke)
    else $error("clock enable high in self refresh");
  chk_sref_min: assert property (
    s_q.st != ST_SREF ##1 s_q.st == ST_SREF |-> s_q.wcnt == tras)
    else $error("self refresh minimum not loaded");
  chk_pd_cke: assert property (
    s_q.st == ST_PDOWN |-> !mem_o.cke)
    else $error("clock enable high in power down");

  cov_refresh: cover property (s_q.st == ST_REFRESH);
  cov_row_break: cover property (s_q.st == ST_PRE_GAP ##[1:40] ack_o);
  cov_sref_exit: cover property (s_q.st == ST_SREF_EXIT);
  cov_err: cover property (irq_o);

endmodule // srpc_ctrl

// ==== srpc_ctrl_tb.sv ====
// self-checking bench for the sdram refresh and power controller
`timescale 1ns/1ps
module srpc_ctrl_tb;
  typedef struct {logic [8:0] a; logic [31:0] v;} srpc_row_t;
  typedef struct {logic [31:0] lp; int lo; int hi;} srpc_lp_t;
  localparam logic [31:0] CFG = srpc_pkg::RST_TIMING_CONFIGURATION;
  localparam int TRP = int'((CFG >> srpc_pkg::CR_TRP_LSB) & 32'hf);
  localparam int TRCD = int'((CFG >> srpc_pkg::CR_TRCD_LSB) & 32'hf);
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [8:0] adr_i = 9'h000;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rd;
  logic ack_o, irq_o, sdram_wait_o;
  srpc_pkg::srpc_mem_t mem_o, cap;
  int refresh_cnt, seq_err, lat, lat_hit, n, wait_seen = 0;
  int miscompares = 0;
  int tests_run = 0;
  // reset values, unmapped place at the end
  srpc_row_t regs[8] = '{'{9'h000, 32'h0}, '{9'h004, 32'h0},
    '{9'h008, CFG}, '{9'h010, 32'h0}, '{9'h01c, 32'h0},
    '{9'h020, 32'h0}, '{9'h024, 32'h0}, '{9'h028, 32'h0}};
  // mode code beside the command it should put on the pins
  srpc_row_t modes[5] = '{'{9'h1, 32'h7}, '{9'h2, 32'h2},
    '{9'h3, 32'h0}, '{9'h4, 32'h1}, '{9'h5, 32'h0}};
  // low-power setting beside the window for clock-enable to fall
  srpc_lp_t lps[4] = '{'{32'h2, 0, 6}, '{32'h1002, 64, 70},
    '{32'h2002, 128, 134}, '{32'h1, 0, 6}};

  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (sdram_wait_o === 1'b1) wait_seen++;

  srpc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .irq_o(irq_o), .sdram_wait_o(sdram_wait_o), .mem_o(mem_o));
  srpc_sdram_model mem (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mem_o),
    .refresh_cnt_o(refresh_cnt), .seq_err_o(seq_err));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // classic cycle; lat counts edges up to the one that sees ack
  task automatic wb(input logic wr, input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= a;
    dat_i <= d;
    lat = 0;
    // outputs are looked at mid-cycle, where they are settled
    do begin
      @(negedge clk_i);
      lat++;
    end while (ack_o !== 1'b1 && lat < 3000);
    if (lat >= 3000) begin
      check("ack", 32'h1, 32'h0);
      print_verdict();
    end
    rd = dat_o;
    cap = mem_o;
    @(posedge clk_i);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  // waits for clock-enable to reach lvl; n is the edges spent
  task automatic wait_cke(input logic lvl);
    n = 0;
    while (mem_o.cke !== lvl && n < 300) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (regs[i]) begin
      wb(1'b0, regs[i].a, 32'h0);
      check("reset value", regs[i].v, rd);
    end
    // unwritten count: no refresh may appear in 300 cycles
    repeat (300) @(posedge clk_i);
    check("early refreshes", 32'h0, refresh_cnt);
    // a read does not make a fresh mode live
    wb(1'b1, 9'h000, 32'h1);
    wb(1'b0, 9'h100, 32'h0);
    check("read command", 32'h5, {29'h0, cap.cmd});
    foreach (modes[i]) begin
      wb(1'b1, 9'h000, {23'h0, modes[i].a});
      wb(1'b1, 9'h101, 32'h0); // bank 1 place
      wb(1'b0, 9'h101, 32'h0);
      check("mode command", modes[i].v, {29'h0, cap.cmd});
    end
    wb(1'b1, 9'h000, 32'h0);
    wb(1'b1, 9'h101, 32'h0);
    // row hit, then the next row of the same bank
    wb(1'b1, 9'h100, 32'h1);
    wb(1'b1, 9'h104, 32'h2);
    lat_hit = lat;
    wb(1'b1, 9'h114, 32'h3);
    check("row break cost", 3 + TRP + TRCD, lat - lat_hit);
    check("command order", 32'h0, seq_err);
    // periodic refresh, count 40, 41 cycles apart
    wb(1'b1, 9'h014, 32'h1);
    wb(1'b0, 9'h01c, 32'h0);
    check("mask set", 32'h1, rd);
    wb(1'b1, 9'h004, 32'd40);
    n = refresh_cnt;
    repeat (400) @(posedge clk_i);
    n = refresh_cnt - n;
    check("refresh rate", 32'h1, {31'h0, n >= 9 && n <= 11});
    wait_cke(1'b1);
    n = 0;
    while (sdram_wait_o !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    wb(1'b0, 9'h004, 32'h0);
    check("register delay", 32'h2, lat);
    check("wait seen", 32'h1, {31'h0, wait_seen > 0});
    // refresh due every second cycle: error flag and interrupt
    wb(1'b1, 9'h004, 32'h1);
    repeat (50) @(posedge clk_i);
    check("irq on error", 32'h1, {31'h0, irq_o});
    wb(1'b1, 9'h004, 32'hfff);
    repeat (20) @(posedge clk_i);
    wb(1'b0, 9'h020, 32'h0);
    check("error flag", 32'h1, rd & 32'h1);
    wb(1'b0, 9'h020, 32'h0);
    check("flag cleared", 32'h0, rd & 32'h1);
    check("irq cleared", 32'h0, {31'h0, irq_o});
    wb(1'b1, 9'h018, 32'h1);
    wb(1'b0, 9'h01c, 32'h0);
    check("mask cleared", 32'h0, rd);
    // low-power entry after the last access, with each timeout
    foreach (lps[i]) begin
      wb(1'b1, 9'h010, lps[i].lp);
      wb(1'b1, 9'h100, 32'h5); // wakes the memory first
      check("awake at access", 32'h1, {31'h0, cap.cke});
      wait_cke(1'b0);
      check("entry delay", 32'h1,
            {31'h0, n >= lps[i].lo && n <= lps[i].hi});
    end
    // the memory clock stops only once the minimum stay has run
    repeat (20) @(negedge clk_i);
    check("clock stopped", 32'h0, {31'h0, mem_o.clk_en});
    wb(1'b1, 9'h100, 32'h6);
    check("self-refresh stay", 32'h0, seq_err);
    wb(1'b1, 9'h010, 32'h3);
    wait_cke(1'b0);
    check("deep power-down", 32'h0, {31'h0, mem_o.cke});
    // no sdram access follows deep power-down
    print_verdict();
  end
endmodule // srpc_ctrl_tb

// ==== srpc_pkg.sv ====
// package of register map, field layout, commands and timing for the sdram controller
package srpc_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_COMMAND_MODE = 8'h00;
  localparam logic [7:0] OFS_REFRESH_TIMER = 8'h04;
  localparam logic [7:0] OFS_TIMING_CONFIGURATION = 8'h08;
  localparam logic [7:0] OFS_LOW_POWER_CONTROL = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK_STATE = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_MEMORY_TYPE_SELECT = 8'h24;
  // sdram window selector: adr_i[8] high addresses the sdram space
  localparam int SDRAM_SEL_BIT = 8;

  // ----------------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [31:0] RST_TIMING_CONFIGURATION = 32'h852372c0;
  localparam int TR_COUNT_W = 12;
  localparam int CR_TRP_LSB = 16;
  localparam int CR_TRCD_LSB = 20;
  localparam int CR_TRAS_LSB = 24;
  localparam int CR_TXSR_LSB = 28;
  localparam int CR_TRC_LSB = 12;
  localparam int LP_SEL_LSB = 0;
  localparam int LP_TMO_LSB = 12;
  localparam int IRQ_RES_BIT = 0;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int TMO_SHORT_CYC = 64;
  localparam int TMO_LONG_CYC = 128;
  localparam int CLK_MHZ = 50;
  localparam int RFSH_PERIOD_MS = 64;
  // longest stay in power-down: one refresh period in whole cycles
  localparam int PD_MAX_CYC = RFSH_PERIOD_MS * CLK_MHZ * 1000;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_NOP = 3'h1,
    MODE_PRECHARGE_ALL = 3'h2,
    MODE_LOAD_MODE = 3'h3,
    MODE_AUTO_REFRESH = 3'h4,
    MODE_EXT_LOAD_MODE = 3'h5,
    MODE_DEEP_PD = 3'h6
  } srpc_mode_t;

  // ras_n, cas_n, we_n
  typedef enum logic [2:0] {
    CMD_NOP = 3'h7,
    CMD_ACTIVE = 3'h3,
    CMD_READ = 3'h5,
    CMD_WRITE = 3'h4,
    CMD_PRECHARGE = 3'h2,
    CMD_REFRESH = 3'h1,
    CMD_LOAD_MODE = 3'h0,
    CMD_BURST_STOP = 3'h6
  } srpc_cmd_t;

  typedef struct packed {
    logic cs_n;
    logic [2:0] cmd;
    logic [1:0] ba;
    logic [12:0] addr;
    logic cke;
    logic clk_en;
    logic a10;
  } srpc_mem_t;

endpackage : srpc_pkg

// ==== srpc_sdram_model.sv ====
// sdram device model that watches the controller's command pins
`timescale 1ns/1ps
module srpc_sdram_model #(
  parameter int TRAS_CYC = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire srpc_pkg::srpc_mem_t mem_i,
  output int refresh_cnt_o,
  output int seq_err_o
);
  logic [2:0] last_q;
  int gap_q;
  int sr_q;
  logic live;
  // -----------------------------------------------------------------
  // command decode
  // -----------------------------------------------------------------
  // a command counts only when selected with the clock enabled
  assign live = !mem_i.cs_n && mem_i.cke && mem_i.cmd != 3'h7;
  // gap_q holds idle cycles since the last real command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refresh_cnt_o <= 0;
      seq_err_o <= 0;
      last_q <= 3'h7;
      gap_q <= 0;
      sr_q <= 0;
    end else begin
      gap_q <= gap_q + 1;
      if (live) begin
        gap_q <= 0;
        last_q <= mem_i.cmd;
        if (mem_i.cmd == srpc_pkg::CMD_REFRESH) begin
          refresh_cnt_o <= refresh_cnt_o + 1;
        end
        // a precharge is followed by at least one idle cycle
        if (last_q == srpc_pkg::CMD_PRECHARGE && gap_q < 1) begin
          seq_err_o <= seq_err_o + 1;
        end
        if (last_q == srpc_pkg::CMD_ACTIVE && gap_q < 1) begin
          seq_err_o <= seq_err_o + 1;
        end
      end
      // self-refresh starts with refresh and clock enable low; minimum stay
      if (!mem_i.cke && (sr_q > 0 ||
          mem_i.cmd == srpc_pkg::CMD_REFRESH)) begin
        sr_q <= sr_q + 1;
      end else begin
        if (sr_q > 0 && sr_q < TRAS_CYC) begin
          seq_err_o <= seq_err_o + 1;
        end
        sr_q <= 0;
      end
    end
  end
endmodule // srpc_sdram_model
